// ---- core/tsr_core.sv ----
// Purpose: Register bank, conversion sequencer and alert logic of a temperature sensor
// Assumes: Serial engine outside delivers decoded bytes; inputs synchronous to clk_sys
// Notes:   Data registers go most significant byte first on the serial link
`include "tsr_map.svh"
`default_nettype none
module tsr_core #(
   parameter logic [31:0] CONV_CYCLES = 32'(`TSR_CONV_TYP_MS * `TSR_CLK_KHZ),
   parameter logic [31:0] PER0_CYCLES = 32'(`TSR_PER_R0_MS * `TSR_CLK_KHZ),
   parameter logic [31:0] PER1_CYCLES = 32'(`TSR_PER_R1_MS * `TSR_CLK_KHZ),
   parameter logic [31:0] PER2_CYCLES = 32'(`TSR_PER_R2_MS * `TSR_CLK_KHZ),
   parameter logic [31:0] PER3_CYCLES = 32'(`TSR_PER_R3_MS * `TSR_CLK_KHZ)
) (
   // Clock and reset
   input  wire logic        clk_sys,
   input  wire logic        rst_n,
   // Decoded serial transaction
   input  wire logic        frm_start,
   input  wire logic        frm_write,
   input  wire logic        wr_byte_valid,
   input  wire logic [7:0]  wr_byte,
   input  wire logic        rd_byte_req,
   output logic [7:0]       rd_byte,
   output logic             rd_byte_valid,
   // Converter result
   input  wire logic [15:0] adc_result,
   // Status and alert
   output logic             conv_active,
   output logic             alert_out
);
   import tsr_pkg::*;

   tsr_phase_t  phase_reg;
   logic [1:0]  ptr_reg;
   logic [7:0]  msb_hold_reg;
   logic [7:0]  rd_lsb_reg;
   logic [15:0] temp_reg;
   logic [15:0] low_reg;
   logic [15:0] high_reg;
   logic [1:0]  rate_reg;
   logic        sleep_reg;
   logic        mode_reg;
   logic        pol_reg;
   logic [1:0]  fault_reg;
   logic        shot_reg;
   logic [31:0] per_cnt_reg;
   logic [31:0] conv_cnt_reg;
   logic        busy_reg;
   logic        fault_on_reg;
   logic [1:0]  hi_cnt_reg;
   logic [1:0]  lo_cnt_reg;
   logic        irq_reg;
   logic        alert_flag;
   logic [15:0] cfg_view;
   logic [15:0] sel_view;
   logic        wr_data;
   logic [15:0] wr_word;
   logic [31:0] per_limit;
   logic        conv_done;
   logic        conv_go;
   logic        shot_go;

   // Comparator state seen through the polarity setting
   // Alert flag derivation
   assign alert_flag = fault_on_reg ? pol_reg : ~pol_reg;

   // Configuration as read by the host
   // Reserved bits zero
   always_comb begin
      cfg_view = 16'h0000;
      cfg_view[`TSR_CFG_ALERT_BIT] = alert_flag;
      cfg_view[`TSR_CFG_RATE_HI:`TSR_CFG_RATE_LO] = rate_reg;
      cfg_view[`TSR_CFG_SLEEP_BIT] = sleep_reg;
      cfg_view[`TSR_CFG_MODE_BIT] = mode_reg;
      cfg_view[`TSR_CFG_POL_BIT] = pol_reg;
      cfg_view[`TSR_CFG_FAULT_HI:`TSR_CFG_FAULT_LO] = fault_reg;
      cfg_view[`TSR_CFG_FIXED1_BIT] = 1'b1;
      cfg_view[`TSR_CFG_SHOT_BIT] = shot_reg;
   end

   always_comb begin
      unique case (ptr_reg)
         `TSR_ADDR_TEMP: sel_view = temp_reg;
         `TSR_ADDR_CFG:  sel_view = cfg_view;
         `TSR_ADDR_LOW:  sel_view = low_reg;
         `TSR_ADDR_HIGH: sel_view = high_reg;
      endcase
   end

   // A data word commits on its second byte only
   // Byte port only access
   assign wr_data = wr_byte_valid & frm_write & ~frm_start & (phase_reg == TSR_PH_LSB);
   assign wr_word = {msb_hold_reg, wr_byte};

   // Byte phase of the transaction
   // Most significant byte first
   always_ff @(posedge clk_sys) begin
      if (!rst_n) begin
         phase_reg <= TSR_PH_PTR;
      end else if (frm_start) begin
         phase_reg <= frm_write ? TSR_PH_PTR : TSR_PH_MSB;
      end else if (wr_byte_valid && frm_write) begin
         unique case (phase_reg)
            TSR_PH_PTR:  phase_reg <= TSR_PH_MSB;
            TSR_PH_MSB:  phase_reg <= TSR_PH_LSB;
            TSR_PH_LSB:  phase_reg <= TSR_PH_DONE;
            TSR_PH_DONE: phase_reg <= TSR_PH_DONE;
         endcase
      end else if (rd_byte_req && !frm_write) begin
         phase_reg <= (phase_reg == TSR_PH_MSB) ? TSR_PH_LSB : TSR_PH_MSB;
      end
   end

   // Pointer register; bits above the two address bits are not stored
   // Two writable bits
   always_ff @(posedge clk_sys) begin
      if (!rst_n) begin
         ptr_reg <= `TSR_RST_PTR;
      end else if (wr_byte_valid && frm_write && !frm_start && phase_reg == TSR_PH_PTR) begin
         ptr_reg <= wr_byte[1:0];
      end
   end

   // First data byte waits here for its partner
   always_ff @(posedge clk_sys) begin
      if (!rst_n) begin
         msb_hold_reg <= 8'h00;
      end else if (wr_byte_valid && frm_write && !frm_start && phase_reg == TSR_PH_MSB) begin
         msb_hold_reg <= wr_byte;
      end
   end

   // Read path; low byte snapshotted with the high one so the word is coherent
   // High byte then low
   always_ff @(posedge clk_sys) begin
      if (!rst_n) begin
         rd_byte       <= 8'h00;
         rd_lsb_reg    <= 8'h00;
         rd_byte_valid <= 1'b0;
      end else begin
         rd_byte_valid <= rd_byte_req & ~frm_write & ~frm_start;
         if (rd_byte_req && !frm_write && !frm_start) begin
            if (phase_reg == TSR_PH_MSB) begin
               rd_byte    <= sel_view[15:8];
               rd_lsb_reg <= sel_view[7:0];
            end else begin
               rd_byte <= rd_lsb_reg;
            end
         end
      end
   end

   // Threshold registers
   // Read-write thresholds
   always_ff @(posedge clk_sys) begin
      if (!rst_n) begin
         low_reg  <= `TSR_RST_LOW;
         high_reg <= `TSR_RST_HIGH;
      end else if (wr_data) begin
         if (ptr_reg == `TSR_ADDR_LOW) begin
            low_reg <= wr_word;
         end
         if (ptr_reg == `TSR_ADDR_HIGH) begin
            high_reg <= wr_word;
         end
      end
   end

   // Writable configuration fields; read-only bits are simply not stored
   // Rate reset and write
   always_ff @(posedge clk_sys) begin
      if (!rst_n) begin
         rate_reg  <= `TSR_RST_RATE;
         sleep_reg <= 1'b0;
         mode_reg  <= 1'b0;
         pol_reg   <= 1'b0;
         fault_reg <= `TSR_RST_FAULT;
      end else if (wr_data && ptr_reg == `TSR_ADDR_CFG) begin
         rate_reg  <= wr_word[`TSR_CFG_RATE_HI:`TSR_CFG_RATE_LO];
         sleep_reg <= wr_word[`TSR_CFG_SLEEP_BIT];
         mode_reg  <= wr_word[`TSR_CFG_MODE_BIT];
         pol_reg   <= wr_word[`TSR_CFG_POL_BIT];
         fault_reg <= wr_word[`TSR_CFG_FAULT_HI:`TSR_CFG_FAULT_LO];
      end
   end

   // Single shot only starts when sleep is (or becomes) set in the same word
   assign shot_go = wr_data & (ptr_reg == `TSR_ADDR_CFG) & wr_word[`TSR_CFG_SHOT_BIT]
                    & wr_word[`TSR_CFG_SLEEP_BIT] & ~busy_reg;

   // Shot bit reads one while a single shot converts
   always_ff @(posedge clk_sys) begin
      if (!rst_n) begin
         shot_reg <= 1'b0;
      end else if (shot_go) begin
         shot_reg <= 1'b1;
      end else if (conv_done) begin
         shot_reg <= 1'b0;
      end
   end

   always_comb begin
      unique case (rate_reg)
         2'h0: per_limit = PER0_CYCLES;
         2'h1: per_limit = PER1_CYCLES;
         2'h2: per_limit = PER2_CYCLES;
         2'h3: per_limit = PER3_CYCLES;
      endcase
   end

   // Continuous conversions start at every period boundary, first one at reset release
   assign conv_go   = (~sleep_reg & ~busy_reg & (per_cnt_reg == 32'h0000_0000)) | shot_go;
   assign conv_done = busy_reg & (conv_cnt_reg == CONV_CYCLES - 32'h0000_0001);

   // Period timer; stopped in sleep so waking starts a conversion at once
   always_ff @(posedge clk_sys) begin
      if (!rst_n || sleep_reg || per_cnt_reg >= per_limit - 32'h0000_0001) begin
         per_cnt_reg <= 32'h0000_0000;
      end else begin
         per_cnt_reg <= per_cnt_reg + 32'h0000_0001;
      end
   end

   // Conversion timer; sleep aborts a continuous conversion but not a single shot
   always_ff @(posedge clk_sys) begin
      if (!rst_n) begin
         busy_reg     <= 1'b0;
         conv_cnt_reg <= 32'h0000_0000;
      end else if (conv_go || conv_done || (sleep_reg && !shot_reg)) begin
         busy_reg     <= conv_go;
         conv_cnt_reg <= 32'h0000_0000;
      end else if (busy_reg) begin
         conv_cnt_reg <= conv_cnt_reg + 32'h0000_0001;
      end
   end

   always_ff @(posedge clk_sys) begin
      if (!rst_n) begin
         temp_reg <= `TSR_RST_TEMP;
      end else if (conv_done) begin
         temp_reg <= adc_result;
      end
   end

   // Consecutive fault filter, signed compare of the new result
   // Fault count use
   always_ff @(posedge clk_sys) begin
      if (!rst_n) begin
         fault_on_reg <= 1'b0;
         hi_cnt_reg   <= 2'h0;
         lo_cnt_reg   <= 2'h0;
      end else if (conv_done) begin
         if (!fault_on_reg) begin
            lo_cnt_reg <= 2'h0;
            if ($signed(adc_result) > $signed(high_reg)) begin
               if (hi_cnt_reg == fault_reg) begin
                  fault_on_reg <= 1'b1;
                  hi_cnt_reg   <= 2'h0;
               end else begin
                  hi_cnt_reg <= hi_cnt_reg + 2'h1;
               end
            end else begin
               hi_cnt_reg <= 2'h0;
            end
         end else begin
            hi_cnt_reg <= 2'h0;
            if ($signed(adc_result) < $signed(low_reg)) begin
               if (lo_cnt_reg == fault_reg) begin
                  fault_on_reg <= 1'b0;
                  lo_cnt_reg   <= 2'h0;
               end else begin
                  lo_cnt_reg <= lo_cnt_reg + 2'h1;
               end
            end else begin
               lo_cnt_reg <= 2'h0;
            end
         end
      end
   end

   // Interrupt mode latch: set by each fault state change, cleared by a host read
   // Interrupt behaviour
   always_ff @(posedge clk_sys) begin
      if (!rst_n) begin
         irq_reg <= 1'b0;
      end else if (conv_done && (hi_cnt_reg == fault_reg) && !fault_on_reg
                   && ($signed(adc_result) > $signed(high_reg))) begin
         irq_reg <= 1'b1;
      end else if (conv_done && (lo_cnt_reg == fault_reg) && fault_on_reg
                   && ($signed(adc_result) < $signed(low_reg))) begin
         irq_reg <= 1'b1;
      end else if (rd_byte_req && !frm_write) begin
         irq_reg <= 1'b0;
      end
   end

   // Pin level and status, both straight from flops
   // Polarity applied
   always_ff @(posedge clk_sys) begin
      if (!rst_n) begin
         alert_out   <= 1'b1;
         conv_active <= 1'b0;
      end else begin
         alert_out   <= (mode_reg ? irq_reg : fault_on_reg) ? pol_reg : ~pol_reg;
         conv_active <= busy_reg;
      end
   end
endmodule : tsr_core
`default_nettype wire

// ---- include/tsr_map.svh ----
// Purpose: Constants for the temperature sensor register bank
// Assumes: 200 MHz system clock
// Notes:   Offsets, field positions, reset values and timing figures
`ifndef TSR_MAP_SVH
`define TSR_MAP_SVH

// Pointer values selecting the data registers
`define TSR_ADDR_TEMP       2'h0
`define TSR_ADDR_CFG        2'h1
`define TSR_ADDR_LOW        2'h2
`define TSR_ADDR_HIGH       2'h3

// Configuration field positions
`define TSR_CFG_ALERT_BIT   5
`define TSR_CFG_RATE_LO     6
`define TSR_CFG_RATE_HI     7
`define TSR_CFG_SLEEP_BIT   8
`define TSR_CFG_MODE_BIT    9
`define TSR_CFG_POL_BIT     10
`define TSR_CFG_FAULT_LO    11
`define TSR_CFG_FAULT_HI    12
`define TSR_CFG_FIXED1_BIT  14
`define TSR_CFG_SHOT_BIT    15

// Reset values
`define TSR_RST_PTR         2'h0
`define TSR_RST_RATE        2'h2
`define TSR_RST_FAULT       2'h0
`define TSR_RST_TEMP        16'h0000
`define TSR_RST_LOW         16'h0000
`define TSR_RST_HIGH        16'h0000

// Timing: clock rate and times in milliseconds
`define TSR_CLK_KHZ         200000
`define TSR_CONV_MIN_MS     22
`define TSR_CONV_TYP_MS     36
`define TSR_CONV_MAX_MS     51
`define TSR_PER_R0_MS       4000
`define TSR_PER_R1_MS       1000
`define TSR_PER_R2_MS       250
`define TSR_PER_R3_MS       125

`endif

// ---- include/tsr_pkg.sv ----
// Purpose: Types for the temperature sensor register bank
// Assumes: Constants live in tsr_map.svh
// Notes:   Gray-coded byte phase of a serial transaction
`default_nettype none
package tsr_pkg;
   // Byte position inside one transaction
   typedef enum logic [1:0] {
      TSR_PH_PTR  = 2'b00,
      TSR_PH_MSB  = 2'b01,
      TSR_PH_LSB  = 2'b11,
      TSR_PH_DONE = 2'b10
   } tsr_phase_t;
endpackage : tsr_pkg
`default_nettype wire

// ---- verification/tb_top.sv ----
// Purpose: Self-checking bench for the sensor register bank
// Assumes: Shortened conversion and period counts
// Notes:   Host model owns the byte port; bench owns reset and converter
`default_nettype none
module tb_top;
   timeunit 1ns;
   timeprecision 1ps;
   localparam int CONV = 20;
   localparam int PER[4] = '{320, 160, 80, 40};
   logic        clk_sys, rst_n, frm_start, frm_write, wr_byte_valid, rd_byte_req, rd_byte_valid;
   logic        conv_active, alert_out;
   logic [7:0]  wr_byte, rd_byte;
   logic [15:0] adc_result, rv;
   int          n_errors, check_count, n, a, b;

   tsr_core #(.CONV_CYCLES(32'd20), .PER0_CYCLES(32'd320), .PER1_CYCLES(32'd160), .PER2_CYCLES(32'd80),
      .PER3_CYCLES(32'd40)) i_tsr_core (.clk_sys, .rst_n, .frm_start, .frm_write, .wr_byte_valid, .wr_byte,
      .rd_byte_req, .rd_byte, .rd_byte_valid, .adc_result, .conv_active, .alert_out);
   tsr_host_model i_tsr_host_model (.clk_sys, .frm_start, .frm_write, .wr_byte_valid, .wr_byte,
      .rd_byte_req, .rd_byte, .rd_byte_valid);

   // 200 MHz clock
   initial begin
      clk_sys = 1'b0;
      forever #2.5 clk_sys = ~clk_sys;
   end

   task automatic check(input string what, input logic [15:0] seen, input logic [15:0] exp);
      check_count++;
      if (seen !== exp) begin
         n_errors++;
         $display("wrong value %s expected %h seen %h", what, exp, seen);
      end
   endtask

   // Pointer-then-data helpers
   task automatic rd(input logic [7:0] p);
      i_tsr_host_model.write_reg(p, 16'h0000, 1'b0);
      i_tsr_host_model.read_reg(rv);
   endtask
   task automatic wr(input logic [7:0] p, input logic [15:0] v);
      i_tsr_host_model.write_reg(p, v, 1'b1);
   endtask

   // Bounded wait for a conversion level; cnt counts the cycles
   task automatic wait_conv(input logic lvl, output int cnt);
      cnt = 0;
      do begin
         @(negedge clk_sys);
         cnt++;
      end while (conv_active !== lvl && cnt < 2000);
      // A wait that runs out is a failure, not a silent pass
      if (conv_active !== lvl) n_errors++;
   endtask
   task automatic wait_idle();
      wait_conv(1'b1, n);
      wait_conv(1'b0, n);
   endtask

   task automatic t_reset();
      i_tsr_host_model.read_reg(rv);
      check("default target", rv, 16'h0000);
      rd(8'h01);
      check("config reset", rv, 16'h40a0);
      rd(8'h02);
      check("low reset", rv, 16'h0000);
      rd(8'h03);
      check("high reset", rv, 16'h0000);
      $display("test done: reset");
   endtask

   task automatic t_regs();
      wr(8'h02, 16'h8123);
      rd(8'h02);
      check("low readback", rv, 16'h8123);
      wr(8'h03, 16'h7ffe);
      rd(8'h03);
      check("high readback", rv, 16'h7ffe);
      i_tsr_host_model.read_reg(rv);
      check("pointer kept", rv, 16'h7ffe);
      rd(8'hfe);
      check("pointer upper bits", rv, 16'h8123);
      wait_idle();
      wr(8'h01, 16'h7fff);
      rd(8'h01);
      check("config fields", rv & 16'hffdf, 16'h5fc0);
      wr(8'h01, 16'h0080);
      $display("test done: regs");
   endtask

   task automatic t_conv();
      wait_idle();
      rd(8'h00);
      check("first result", rv, 16'h0a50);
      adc_result = 16'h0b60;
      rd(8'h00);
      check("result held", rv, 16'h0a50);
      // Read back before the next conversion can overwrite a stray write
      wr(8'h00, 16'h1234);
      rd(8'h00);
      check("result write ignored", rv, 16'h0a50);
      wait_idle();
      rd(8'h00);
      check("new result", rv, 16'h0b60);
      $display("test done: conv");
   endtask

   task automatic t_rate();
      for (int c = 0; c < 4; c++) begin
         wr(8'h01, {8'h00, 2'(c), 6'h00});
         wait_conv(1'b0, n);
         wait_conv(1'b1, n);
         wait_conv(1'b0, a);
         wait_conv(1'b1, b);
         check("conversion length", 16'(a), 16'(CONV));
         check("conversion period", 16'(a + b), 16'(PER[c]));
      end
      $display("test done: rate");
   endtask

   task automatic t_alert();
      wr(8'h03, 16'h0100);
      wr(8'h02, 16'h0080);
      wait_idle();
      wait_idle();
      check("alert low active", {15'h0, alert_out}, 16'h0000);
      rd(8'h01);
      check("alert flag", rv, 16'h40c0);
      wr(8'h01, 16'h04c0);
      repeat (2) @(negedge clk_sys);
      check("alert high active", {15'h0, alert_out}, 16'h0001);
      adc_result = 16'h0010;
      wait_idle();
      wait_idle();
      check("alert cleared", {15'h0, alert_out}, 16'h0000);
      // Interrupt mode: the fault change just seen stays latched until a read
      wr(8'h01, 16'h06c0);
      repeat (2) @(negedge clk_sys);
      check("interrupt pending", {15'h0, alert_out}, 16'h0001);
      rd(8'h01);
      check("interrupt config", rv, 16'h46c0);
      check("interrupt cleared", {15'h0, alert_out}, 16'h0000);
      adc_result = 16'h0b60;
      wait_idle();
      check("interrupt on fault", {15'h0, alert_out}, 16'h0001);
      $display("test done: alert");
   endtask

   task automatic t_sleep();
      wait_idle();
      wr(8'h01, 16'h0180);
      a = 0;
      repeat (200) begin
         @(negedge clk_sys);
         if (conv_active !== 1'b0) a++;
      end
      check("sleep quiet", 16'(a), 16'h0000);
      // Single shot while asleep; its bit reads one until the result lands
      wr(8'h01, 16'h8180);
      rd(8'h01);
      check("shot running", rv, 16'hc180);
      wait_conv(1'b0, n);
      rd(8'h01);
      check("shot finished", rv, 16'h4180);
      wr(8'h01, 16'h0080);
      wait_conv(1'b1, n);
      check("wake restart", 16'(n > 3), 16'h0000);
      $display("test done: sleep");
   endtask

   task automatic results();
      $display("checks %0d mismatches %0d", check_count, n_errors);
      if (n_errors == 0 && check_count > 0)
         $display("NO MISMATCHES");
      else
         $display("MISMATCHES SEEN");
      $finish;
   endtask

   // Main sequence
   initial begin
      rst_n = 1'b0;
      adc_result = 16'h0a50;
      n_errors = 0;
      check_count = 0;
      repeat (6) @(negedge clk_sys);
      rst_n = 1'b1;
      t_reset();
      t_regs();
      t_conv();
      t_rate();
      t_alert();
      t_sleep();
      results();
   end

   // Watchdog, well past the expected few thousand cycles
   initial begin
      #200us;
      n_errors++;
      results();
   end
endmodule // tb_top
`default_nettype wire

// ---- verification/tsr_core_props.sv ----
// Purpose: Port-level checks on the sensor register bank
// Assumes: Single clock domain, synchronous active-low reset
// Notes:   Conversion length compared against the bound parameter
`default_nettype none
module tsr_core_chk #(
   parameter logic [31:0] CONV_CYCLES = 32'h14
) (
   // Clock and reset
   input wire logic       clk_sys,
   input wire logic       rst_n,
   // Byte port
   input wire logic       frm_start,
   input wire logic       frm_write,
   input wire logic       rd_byte_req,
   input wire logic [7:0] rd_byte,
   input wire logic       rd_byte_valid,
   // Status
   input wire logic       conv_active,
   input wire logic       alert_out
);
   timeunit 1ns;
   timeprecision 1ps;
   logic [31:0] run_reg;

   default clocking cb @(posedge clk_sys);
   endclocking
   default disable iff (!rst_n);

   // Cycles spent in the current conversion
   always_ff @(posedge clk_sys) begin
      if (!rst_n || !conv_active) run_reg <= 32'h0;
      else run_reg <= run_reg + 32'h1;
   end

   a_read_answer: assert property (rd_byte_req && !frm_write && !frm_start |=> rd_byte_valid)
      else $error("read byte not answered");
   a_read_quiet: assert property (!(rd_byte_req && !frm_write && !frm_start) |=> !rd_byte_valid)
      else $error("read byte answered without a request");
   a_byte_hold: assert property (!rd_byte_valid |-> $stable(rd_byte))
      else $error("read byte moved without a valid");
   a_conv_length: assert property ($fell(conv_active) |-> run_reg == CONV_CYCLES)
      else $error("conversion length off");
   a_conv_gap: assert property ($fell(conv_active) |-> !conv_active [*8])
      else $error("conversion restarted too soon");
   a_first_conv: assert property ($rose(rst_n) |-> ##[1:3] conv_active)
      else $error("no conversion after reset");
   a_reset_quiet: assert property ($rose(rst_n) |-> !rd_byte_valid && !conv_active && rd_byte == 8'h00)
      else $error("outputs not cleared by reset");
   a_alert_idle: assert property ($rose(rst_n) |-> alert_out)
      else $error("alert not idle high after reset");
endmodule // tsr_core_chk

bind tsr_core tsr_core_chk #(.CONV_CYCLES(CONV_CYCLES)) i_tsr_core_chk (.clk_sys, .rst_n, .frm_start,
   .frm_write, .rd_byte_req, .rd_byte, .rd_byte_valid, .conv_active, .alert_out);
`default_nettype wire

// ---- verification/tsr_host_model.sv ----
// Purpose: Host controller model issuing byte-level register transactions
// Assumes: Drives on falling clk_sys edges
// Notes:   Released byte lines show the inverse of the last byte
`default_nettype none
module tsr_host_model (
   // Clock
   input  wire logic       clk_sys,
   // Byte port toward the sensor
   output logic            frm_start,
   output logic            frm_write,
   output logic            wr_byte_valid,
   output logic [7:0]      wr_byte,
   output logic            rd_byte_req,
   input  wire logic [7:0] rd_byte,
   input  wire logic       rd_byte_valid
);
   timeunit 1ns;
   timeprecision 1ps;

   // Idle bus at time zero
   initial begin
      frm_start = 1'b0;
      frm_write = 1'b0;
      wr_byte_valid = 1'b0;
      wr_byte = 8'h00;
      rd_byte_req = 1'b0;
   end

   // One-cycle start pulse, direction held for the frame
   task automatic open_frame(input logic wr);
      @(negedge clk_sys);
      frm_start = 1'b1;
      frm_write = wr;
      @(negedge clk_sys);
      frm_start = 1'b0;
   endtask

   // Pointer byte, then, when full is set, high byte then low byte
   task automatic write_reg(input logic [7:0] ptr, input logic [15:0] val, input logic full);
      open_frame(1'b1);
      wr_byte_valid = 1'b1;
      wr_byte = ptr;
      if (full) begin
         @(negedge clk_sys);
         wr_byte = val[15:8];
         @(negedge clk_sys);
         wr_byte = val[7:0];
      end
      @(negedge clk_sys);
      wr_byte_valid = 1'b0;
      wr_byte = ~wr_byte;
   endtask

   // Two back-to-back byte requests; a missing answer yields unknowns
   task automatic read_reg(output logic [15:0] val);
      open_frame(1'b0);
      rd_byte_req = 1'b1;
      for (int i = 0; i < 2; i++) begin
         @(negedge clk_sys);
         val = {val[7:0], (rd_byte_valid === 1'b1) ? rd_byte : 8'hxx};
      end
      rd_byte_req = 1'b0;
   endtask
endmodule // tsr_host_model
`default_nettype wire
